// ===== design/tae_annunciator.sv
/*
 * Front-panel annunciation and metering for a breaker trip unit: trip
 * cause latching, step interrogation of trip currents, high-load timing,
 * thermal memory, present and peak demand and rolling energy.
 * Assumes the protection logic gives one-cycle trip pulses on clk and that
 * pushbuttons and the overload level come from pins (synchronised here).
 */
`timescale 1ns/1ps
`include "tae_regs.svh"

module tae_annunciator
    import tae_pkg::*;
#(
    parameter int CUR_W       = 12,
    parameter int PWR_W       = 12,
    parameter int TICK_CYCLES = `TAE_TICK_CYCLES,
    parameter int HILOAD_S    = `TAE_HILOAD_S,
    parameter int WINDOW_S    = `TAE_WINDOW_S
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ground_fitted,
    input  wire logic [2:0]              ld_setting,
    input  wire logic                    overload_pin,
    input  wire logic                    step_btn_pin,
    input  wire logic                    reset_btn_pin,
    input  wire logic                    peak_reset_btn_pin,
    input  wire logic                    trip_ld,
    input  wire logic                    trip_sd,
    input  wire logic                    trip_fast_fault_trip_code,
    input  wire logic                    trip_gnd,
    input  wire logic                    trip_override,
    input  wire logic [CUR_W-1:0]        cur_a,
    input  wire logic [CUR_W-1:0]        cur_b,
    input  wire logic [CUR_W-1:0]        cur_c,
    input  wire logic [CUR_W-1:0]        cur_g,
    input  wire logic signed [PWR_W-1:0] power,
    output logic                         led_long_delay,
    output logic                         led_short_delay,
    output logic                         led_fast_fault_trip_code,
    output logic                         led_ground,
    output logic                         led_high_load,
    output logic [3:0]                   led_cur_ptr,
    output logic [2:0]                   led_met_ptr,
    output logic                         relay_long_delay,
    output logic                         relay_short_circuit,
    output logic                         relay_ground,
    output logic                         relay_high_load,
    output logic                         thermal_memory,
    output logic [3:0]                   disp_msg,
    output logic [15:0]                  disp_value
);

    initial begin
        if (CUR_W < 1 || CUR_W > 16 || PWR_W < 2 || PWR_W > 16 || TICK_CYCLES < 2
            || HILOAD_S < 1 || WINDOW_S < 1)
            $error("tae_annunciator: unsupported parameter values");
    end

    function automatic tae_cur_ptr_t next_cur(tae_cur_ptr_t p, logic gnd);
        case (p)
            TAE_PTR_A: next_cur = TAE_PTR_B;
            TAE_PTR_B: next_cur = TAE_PTR_C;
            TAE_PTR_C: next_cur = gnd ? TAE_PTR_G : TAE_PTR_A;
            default:   next_cur = TAE_PTR_A;
        endcase
    endfunction

    // Pin synchronisers
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] btn_prev_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q    <= 4'h0;
            sync2_q    <= 4'h0;
            btn_prev_q <= 4'h0;
        end else begin
            sync1_q    <= {peak_reset_btn_pin, reset_btn_pin, step_btn_pin, overload_pin};
            sync2_q    <= sync1_q;
            btn_prev_q <= sync2_q;
        end
    end
    logic overload;
    logic step_p;
    logic reset_p;
    logic peak_rst_p;
    assign overload   = sync2_q[0];
    assign step_p     = sync2_q[1] & ~btn_prev_q[1];
    assign reset_p    = sync2_q[2] & ~btn_prev_q[2];
    assign peak_rst_p = sync2_q[3] & ~btn_prev_q[3];

    // One-second time base
    logic [31:0] tick_cnt_q;
    logic        tick;
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            tick_cnt_q <= 32'h0;
        else if (tick)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // Trip latching; a new trip while latched is ignored until reset
    logic      any_trip;
    logic      tripped_q;
    logic [3:0] cause_q;
    logic      override_q;
    assign any_trip = trip_ld | trip_sd | trip_fast_fault_trip_code | trip_gnd | trip_override;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tripped_q  <= 1'b0;
            cause_q    <= `TAE_MSG_NONE;
            override_q <= 1'b0;
        end else if (any_trip && !tripped_q) begin
            tripped_q  <= 1'b1;
            override_q <= trip_override;
            if (trip_override)
                cause_q <= `TAE_MSG_OVERRIDE_TRIP_CODE;
            else if (trip_fast_fault_trip_code)
                cause_q <= `TAE_MSG_FAST_FAULT_TRIP_CODE;
            else if (trip_sd)
                cause_q <= `TAE_MSG_SDT;
            else if (trip_gnd)
                cause_q <= `TAE_MSG_GNDT;
            else
                cause_q <= `TAE_MSG_LDT;
        end else if (reset_p) begin
            tripped_q  <= 1'b0;
            cause_q    <= `TAE_MSG_NONE;
            override_q <= 1'b0;
        end
    end

    // Trip currents captured at the trip, cleared on reset
    logic [CUR_W-1:0] cap_q [4];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++)
                cap_q[i] <= '0;
        end else if (any_trip && !tripped_q) begin
            cap_q[0] <= cur_a;
            cap_q[1] <= cur_b;
            cap_q[2] <= cur_c;
            cap_q[3] <= cur_g;
        end else if (reset_p) begin
            for (int i = 0; i < 4; i++)
                cap_q[i] <= '0;
        end
    end

    // Panel state and pointers
    tae_state_t   state_q;
    tae_cur_ptr_t cur_ptr_q;
    tae_met_ptr_t met_ptr_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_q <= TAE_ST_METER;
        else begin
            case (state_q)
                TAE_ST_METER:   if (any_trip) state_q <= TAE_ST_TRIPMSG;
                TAE_ST_TRIPMSG: begin
                    if (reset_p)
                        state_q <= TAE_ST_METER;
                    else if (step_p)
                        state_q <= TAE_ST_TRIPCUR;
                end
                TAE_ST_TRIPCUR: if (reset_p) state_q <= TAE_ST_METER;
                default:        state_q <= TAE_ST_METER;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cur_ptr_q <= TAE_PTR_A;
        else if (state_q == TAE_ST_TRIPCUR && step_p)
            cur_ptr_q <= next_cur(cur_ptr_q, ground_fitted);
        else if (!ground_fitted && cur_ptr_q == TAE_PTR_G)
            cur_ptr_q <= TAE_PTR_A;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            met_ptr_q <= TAE_MET_PEAK;
        else if (state_q == TAE_ST_METER && step_p) begin
            case (met_ptr_q)
                TAE_MET_PEAK:    met_ptr_q <= TAE_MET_PRESENT;
                TAE_MET_PRESENT: met_ptr_q <= TAE_MET_ENERGY;
                default:         met_ptr_q <= TAE_MET_PEAK;
            endcase
        end
    end

    // High-load timer and blink on each second
    logic [15:0] ovl_sec_q;
    logic        blink_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ovl_sec_q <= 16'h0;
        else if (!overload)
            ovl_sec_q <= 16'h0;
        else if (tick && ovl_sec_q <= 16'(HILOAD_S)) // Extra tick: first second may be short
            ovl_sec_q <= ovl_sec_q + 16'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            blink_q <= 1'b0;
        else if (tick)
            blink_q <= ~blink_q;
    end

    // Thermal memory: decay time grows with the long-delay setting
    logic [15:0] mem_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            mem_q <= 16'h0;
        else if (trip_ld && !tripped_q)
            mem_q <= 16'(`TAE_MEM_MIN_S + ld_setting * `TAE_MEM_STEP_S);
        else if (tick && mem_q != 16'h0)
            mem_q <= mem_q - 16'h1;
    end

    // Metering: present demand, jumping window peak, energy
    logic signed [PWR_W-1:0] present_q;
    logic [31:0]             win_sum_q;
    logic [15:0]             win_sec_q;
    logic [15:0]             peak_q;
    logic [13:0]             energy_q;
    logic [31:0]             energy_frac_q;
    logic [PWR_W-1:0]        pos_pwr;
    logic [31:0]             win_avg;
    assign pos_pwr = power[PWR_W-1] ? '0 : power;
    assign win_avg = (win_sum_q + 32'(pos_pwr)) / 32'(WINDOW_S);

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            present_q <= '0;
        else if (tick)
            present_q <= power;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_sum_q <= 32'h0;
            win_sec_q <= 16'h0;
        end else if (tick) begin
            if (win_sec_q == 16'(WINDOW_S - 1)) begin
                win_sum_q <= 32'h0;
                win_sec_q <= 16'h0;
            end else begin
                win_sum_q <= win_sum_q + 32'(pos_pwr);
                win_sec_q <= win_sec_q + 16'h1;
            end
        end
    end

    // Peak stays zero until a full window ends; trips leave it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            peak_q <= 16'h0;
        else if (tick && win_sec_q == 16'(WINDOW_S - 1) && win_avg[15:0] > peak_q)
            peak_q <= win_avg[15:0];
        else if (peak_rst_p)
            peak_q <= 16'h0;
    end

    // Energy in 0.01 MWH steps; 360 power-seconds per step, power in 0.1 MW counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            energy_q      <= 14'h0;
            energy_frac_q <= 32'h0;
        end else if (tick) begin
            if (energy_frac_q + 32'(pos_pwr) >= 32'h168) begin
                energy_frac_q <= energy_frac_q + 32'(pos_pwr) - 32'h168;
                if (energy_q + 14'h1 >= `TAE_ENERGY_WRAP)
                    energy_q <= 14'h0;
                else
                    energy_q <= energy_q + 14'h1;
            end else
                energy_frac_q <= energy_frac_q + 32'(pos_pwr);
        end
    end

    // Outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_long_delay   <= 1'b0;
            led_short_delay  <= 1'b0;
            led_fast_fault_trip_code         <= 1'b0;
            led_ground       <= 1'b0;
            relay_long_delay <= 1'b0;
            relay_short_circuit <= 1'b0;
            relay_ground     <= 1'b0;
            led_high_load    <= 1'b0;
            relay_high_load  <= 1'b0;
            thermal_memory   <= 1'b0;
            led_cur_ptr      <= 4'h0;
            led_met_ptr      <= 3'h0;
        end else begin
            led_long_delay   <= (tripped_q && cause_q == `TAE_MSG_LDT)
                                || (!tripped_q && overload && blink_q);
            led_short_delay  <= tripped_q && cause_q == `TAE_MSG_SDT;
            led_fast_fault_trip_code         <= tripped_q && (cause_q == `TAE_MSG_FAST_FAULT_TRIP_CODE
                                || cause_q == `TAE_MSG_OVERRIDE_TRIP_CODE);
            led_ground       <= tripped_q && cause_q == `TAE_MSG_GNDT;
            relay_long_delay <= tripped_q && cause_q == `TAE_MSG_LDT;
            relay_short_circuit <= tripped_q && (cause_q == `TAE_MSG_FAST_FAULT_TRIP_CODE
                                || cause_q == `TAE_MSG_OVERRIDE_TRIP_CODE
                                || cause_q == `TAE_MSG_SDT);
            relay_ground     <= tripped_q && cause_q == `TAE_MSG_GNDT;
            led_high_load    <= ovl_sec_q > 16'(HILOAD_S);
            relay_high_load  <= ovl_sec_q > 16'(HILOAD_S);
            thermal_memory   <= mem_q != 16'h0;
            led_cur_ptr      <= (state_q == TAE_ST_METER) ? 4'h0 : cur_ptr_q;
            led_met_ptr      <= (state_q == TAE_ST_METER) ? met_ptr_q : 3'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            disp_msg   <= `TAE_MSG_NONE;
            disp_value <= 16'h0;
        end else begin
            disp_msg   <= `TAE_MSG_VALUE;
            disp_value <= 16'h0;
            case (state_q)
                TAE_ST_TRIPMSG: disp_msg <= cause_q;
                TAE_ST_TRIPCUR: begin
                    if (override_q)
                        disp_msg <= `TAE_MSG_OVER_RANGE_CODE;
                    else
                        case (cur_ptr_q)
                            TAE_PTR_B: disp_value <= 16'(cap_q[1]);
                            TAE_PTR_C: disp_value <= 16'(cap_q[2]);
                            TAE_PTR_G: disp_value <= 16'(cap_q[3]);
                            default:   disp_value <= 16'(cap_q[0]);
                        endcase
                end
                default: begin
                    if (overload && blink_q)
                        disp_msg <= `TAE_MSG_OVERLOAD_PICKUP_CODE;
                    else
                        case (met_ptr_q)
                            TAE_MET_PRESENT: begin
                                if (present_q < 0 && blink_q)
                                    disp_msg <= `TAE_MSG_REVERSE_POWER_CODE;
                                else
                                    disp_value <= 16'(present_q < 0 ? -present_q
                                                               : present_q);
                            end
                            TAE_MET_ENERGY: disp_value <= 16'(energy_q);
                            default:        disp_value <= peak_q;
                        endcase
                end
            endcase
        end
    end

endmodule

// ===== design/tae_pkg.sv
/*
 * Types for the trip annunciation and energy display block.
 * Assumes nothing of its surroundings.
 */
package tae_pkg;

    typedef enum logic [3:0] {
        TAE_PTR_A = 4'h1,
        TAE_PTR_B = 4'h2,
        TAE_PTR_C = 4'h4,
        TAE_PTR_G = 4'h8
    } tae_cur_ptr_t;

    typedef enum logic [2:0] {
        TAE_MET_PEAK    = 3'h1,
        TAE_MET_PRESENT = 3'h2,
        TAE_MET_ENERGY  = 3'h4
    } tae_met_ptr_t;

    typedef enum logic [3:0] {
        TAE_ST_METER  = 4'h1,
        TAE_ST_TRIPMSG = 4'h2,
        TAE_ST_TRIPCUR = 4'h4,
        TAE_ST_SPARE  = 4'h8
    } tae_state_t;

endpackage

// ===== design/tae_regs.svh
/*
 * Constants for the trip annunciation and energy display block: display
 * message codes, timing counts and metering limits.
 * Assumes a 100 MHz clock and that the includer needs nothing else.
 */
`ifndef TAE_REGS_SVH
`define TAE_REGS_SVH

`define TAE_CLK_HZ            100000000
`define TAE_TICK_CYCLES       (`TAE_CLK_HZ)
`define TAE_HILOAD_S          40
`define TAE_WINDOW_S          300
`define TAE_MEM_MIN_S         60
`define TAE_MEM_MAX_S         720
`define TAE_MEM_STEP_S        94

// Display message codes, a tag in the top nibble of the display word
`define TAE_MSG_NONE          4'h0
`define TAE_MSG_LDT           4'h1
`define TAE_MSG_OVERLOAD_PICKUP_CODE          4'h2
`define TAE_MSG_SDT           4'h3
`define TAE_MSG_FAST_FAULT_TRIP_CODE          4'h4
`define TAE_MSG_GNDT          4'h5
`define TAE_MSG_OVERRIDE_TRIP_CODE          4'h6
`define TAE_MSG_OVER_RANGE_CODE          4'h7
`define TAE_MSG_REVERSE_POWER_CODE          4'h8
`define TAE_MSG_VALUE         4'hF

// Energy wrap: 99.99 MWH in 0.01 MWH counts is 9999 plus one
`define TAE_ENERGY_WRAP       14'h2710

`endif

// ===== tb/tae_monitor.sv
/* Port checker for tae_annunciator: trip latching, high-load timing and
   pointer exclusivity. Assumes binding to the annunciator. */
`timescale 1ns/1ps
module tae_monitor #(
    parameter int TICK_CYCLES = 10,
    parameter int HILOAD_S    = 40
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       overload_pin,
    input wire logic       reset_btn_pin,
    input wire logic       trip_ld,
    input wire logic       trip_sd,
    input wire logic       trip_fast_fault_trip_code,
    input wire logic       trip_gnd,
    input wire logic       trip_override,
    input wire logic       led_long_delay,
    input wire logic       led_short_delay,
    input wire logic       led_fast_fault_trip_code,
    input wire logic       led_ground,
    input wire logic       led_high_load,
    input wire logic [3:0] led_cur_ptr,
    input wire logic [2:0] led_met_ptr,
    input wire logic       relay_long_delay,
    input wire logic       relay_short_circuit,
    input wire logic       relay_high_load,
    input wire logic [3:0] disp_msg
);
    logic       any_trip_q;
    logic [3:0] since_rst_q;
    int         ol_run_q;
    logic       idle;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A pulse one cycle back is already latched, so a new one is ignored
    assign idle = !(led_long_delay | led_short_delay | led_fast_fault_trip_code | led_ground) && !any_trip_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_trip_q <= 1'b0;
        end else begin
            any_trip_q <= trip_ld | trip_sd | trip_fast_fault_trip_code | trip_gnd | trip_override;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_rst_q <= 4'hF;
        end else begin
            since_rst_q <= reset_btn_pin ? 4'h0 : since_rst_q + {3'h0, since_rst_q != 4'hF};
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ol_run_q <= 0;
        end else begin
            ol_run_q <= overload_pin ? ol_run_q + 1 : 0;
        end
    end
    sequence s_ld_shown;
        led_long_delay && relay_long_delay && disp_msg == 4'h1;
    endsequence
    property p_ld_trip;
        trip_ld && !(trip_sd | trip_fast_fault_trip_code | trip_gnd | trip_override) && idle |-> ##2 s_ld_shown;
    endproperty
    a_ld_trip: assert property (p_ld_trip) else $error("long trip not shown");
    property p_fast_fault_trip_code_trip;
        trip_fast_fault_trip_code && !trip_override && idle |-> ##2 led_fast_fault_trip_code && relay_short_circuit && disp_msg == 4'h4;
    endproperty
    a_fast_fault_trip_code_trip: assert property (p_fast_fault_trip_code_trip) else $error("fast trip not shown");
    property p_sd_trip;
        trip_sd && !(trip_fast_fault_trip_code | trip_override) && idle |-> ##2 led_short_delay && disp_msg == 4'h3;
    endproperty
    a_sd_trip: assert property (p_sd_trip) else $error("short trip not shown");
    property p_ovr_trip;
        trip_override && idle |-> ##2 led_fast_fault_trip_code && disp_msg == 4'h6;
    endproperty
    a_ovr_trip: assert property (p_ovr_trip) else $error("override trip not shown");
    property p_latch;
        $fell(relay_long_delay) || $fell(relay_short_circuit) |-> since_rst_q < 4'hA;
    endproperty
    a_latch: assert property (p_latch) else $error("relay dropped without reset");
    property p_hl_min;
        $rose(led_high_load) |-> ol_run_q >= HILOAD_S * TICK_CYCLES;
    endproperty
    a_hl_min: assert property (p_hl_min) else $error("high load too early");
    property p_hl_pair;
        $rose(relay_high_load) |-> ol_run_q >= HILOAD_S * TICK_CYCLES;
    endproperty
    a_hl_pair: assert property (p_hl_pair) else $error("high load relay too early");
    property p_hl_drop;
        !overload_pin [*6] |-> !led_high_load;
    endproperty
    a_hl_drop: assert property (p_hl_drop) else $error("high load held");
    property p_ptr;
        $onehot0(led_cur_ptr) && $onehot0(led_met_ptr) && !(|led_cur_ptr && |led_met_ptr);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer LEDs clash");
endmodule

// ===== tb/tae_panel_model.sv
/* Operator panel model: step, trip-reset and peak-reset buttons.
   Assumes the annunciator runs on the same clk. */
`timescale 1ns/1ps
module tae_panel_model (
    input  wire logic clk,
    output logic      step_btn_pin,
    output logic      reset_btn_pin,
    output logic      peak_reset_btn_pin
);
    initial begin
        step_btn_pin = 1'b0;
        reset_btn_pin = 1'b0;
        peak_reset_btn_pin = 1'b0;
    end
    // Held over the sync chain, then low long enough to rearm the edge
    task automatic press(input int which);
        @(posedge clk);
        #1;
        step_btn_pin = (which == 0);
        reset_btn_pin = (which == 1);
        peak_reset_btn_pin = (which == 2);
        repeat (4) @(posedge clk);
        #1;
        step_btn_pin = 1'b0;
        reset_btn_pin = 1'b0;
        peak_reset_btn_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule

// ===== tb/testbench.sv
/* Self-checking bench for tae_annunciator with shortened time counts.
   Assumes the panel model and the bound monitor. */
`timescale 1ns/1ps
module testbench;
    localparam int TICK = 10;
    localparam int WIN  = 3;
    typedef struct packed {
        logic [4:0] trips;
        logic [3:0] msg;
        logic [3:0] leds;
        logic [2:0] relays;
    } tae_row_t;
    localparam tae_row_t ROWS [5] = '{'{5'h01, 4'h1, 4'h1, 3'h1}, '{5'h02, 4'h3, 4'h2, 3'h2},
        '{5'h04, 4'h4, 4'h4, 3'h2}, '{5'h08, 4'h5, 4'h8, 3'h4}, '{5'h10, 4'h6, 4'h4, 3'h2}};
    localparam logic [3:0] PTRS [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
    logic               clk, rst, ovl, step_p, reset_p, peak_p, gnd;
    logic [4:0]         trips;
    logic [11:0]        cur [4];
    logic signed [11:0] power;
    logic               led_ld, led_sd, led_in, led_gn, led_hl, thermal;
    logic               rl_ld, rl_sc, rl_gn, rl_hl, seen_a, seen_b, last_ld;
    logic [3:0]         cur_ptr, msg;
    logic [2:0]         met_ptr, ld_set;
    logic [15:0]        value, energy;
    int                 fail_count, num_checks, toggles;
    tae_annunciator #(.TICK_CYCLES(TICK), .HILOAD_S(4), .WINDOW_S(WIN)) i_tae_annunciator (
        .clk(clk), .rst(rst), .ground_fitted(gnd), .ld_setting(ld_set), .overload_pin(ovl),
        .step_btn_pin(step_p), .reset_btn_pin(reset_p), .peak_reset_btn_pin(peak_p),
        .trip_ld(trips[0]), .trip_sd(trips[1]), .trip_fast_fault_trip_code(trips[2]), .trip_gnd(trips[3]),
        .trip_override(trips[4]), .cur_a(cur[0]), .cur_b(cur[1]), .cur_c(cur[2]),
        .cur_g(cur[3]), .power(power), .led_long_delay(led_ld), .led_short_delay(led_sd),
        .led_fast_fault_trip_code(led_in), .led_ground(led_gn), .led_high_load(led_hl), .led_cur_ptr(cur_ptr),
        .led_met_ptr(met_ptr), .relay_long_delay(rl_ld), .relay_short_circuit(rl_sc),
        .relay_ground(rl_gn), .relay_high_load(rl_hl), .thermal_memory(thermal),
        .disp_msg(msg), .disp_value(value));
    tae_panel_model i_tae_panel_model (.clk(clk), .step_btn_pin(step_p),
        .reset_btn_pin(reset_p), .peak_reset_btn_pin(peak_p));
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic press(input int which);
        i_tae_panel_model.press(which);
    endtask
    task automatic trip(input logic [4:0] t);
        @(posedge clk);
        #1;
        trips = t;
        cyc(1);
        trips = 5'h00;
        cyc(3);
    endtask
    // Navigation only: the pointer is read to know how far to step
    task automatic goto_met(input logic [2:0] target);
        for (int k = 0; k < 3 && met_ptr !== target; k++) press(0);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial begin
        {rst, ovl, trips, fail_count, num_checks} = {1'b1, 1'b0, 5'h00, 64'h0};
        foreach (cur[k]) cur[k] = 12'h000;
        {gnd, ld_set} = {1'b1, 3'h0};
        power = 12'sh064;
        cyc(5);
        rst = 1'b0;
        cyc(2);
        check("met_ptr", 20'(met_ptr), 20'h1);
        check("peak", {msg, value}, 20'hF0000);
        press(0);
        cyc(2 * TICK);
        check("met_ptr", 20'(met_ptr), 20'h2);
        check("present", {msg, value}, 20'hF0064);
        power = -12'sh005;
        {seen_a, seen_b} = 2'b00;
        repeat (4 * TICK) begin
            cyc(1);
            seen_a |= (msg === 4'h8);
            seen_b |= (msg === 4'hF);
        end
        check("reverse", 20'({seen_a, seen_b}), 20'h3);
        power = 12'sh064;
        press(0);
        check("met_ptr", 20'(met_ptr), 20'h4);
        press(0);
        check("met_ptr", 20'(met_ptr), 20'h1);
        cyc(4 * WIN * TICK);
        check("peak", {msg, value}, 20'hF0064);
        $display("metering test done");
        ovl = 1'b1;
        cyc(4 * TICK);
        check("hl_early", 20'({led_hl, rl_hl}), 20'h0);
        {seen_a, toggles, last_ld} = '0;
        repeat (6 * TICK) begin
            cyc(1);
            seen_a |= (msg === 4'h2);
            toggles += int'(led_ld !== last_ld);
            last_ld = led_ld;
        end
        check("hl_on", 20'({led_hl, rl_hl}), 20'h3);
        check("pickup", 20'({seen_a, toggles > 2}), 20'h3);
        ovl = 1'b0;
        cyc(6);
        check("hl_off", 20'({led_hl, rl_hl}), 20'h0);
        $display("high load test done");
        for (int r = 0; r < 5; r++) begin
            foreach (cur[k]) cur[k] = 12'(16 * r + 3 * k + 5);
            trip(ROWS[r].trips);
            check("msg", 20'(msg), 20'(ROWS[r].msg));
            check("leds", 20'({led_gn, led_in, led_sd, led_ld}), 20'(ROWS[r].leds));
            check("relays", 20'({rl_gn, rl_sc, rl_ld}), 20'(ROWS[r].relays));
            check("met_off", 20'(met_ptr), 20'h0);
            if (r == 0) check("thermal", 20'(thermal), 20'h1);
            for (int k = 0; k < 5; k++) begin
                press(0);
                check("ptr", 20'(cur_ptr), 20'(PTRS[k]));
                check("cur", {msg, value}, (r == 4) ? 20'h70000 :
                    {8'hF0, cur[k % 4]});
            end
            press(1);
            check("cleared", 20'({led_gn, led_in, led_sd, led_ld, rl_gn, rl_sc, rl_ld}),
                20'h0);
            check("msg_clr", 20'(msg), 20'hF);
            $display("trip row %0d done", r);
        end
        goto_met(3'h1);
        check("peak_kept", {msg, value}, 20'hF0064);
        power = 12'sh000;
        cyc(600);
        check("thermal", 20'(thermal), 20'h0);
        goto_met(3'h4);
        energy = value;
        check("energy_up", 20'(energy != 16'h0), 20'h1);
        trip(5'h04);
        press(1);
        press(2);
        goto_met(3'h4);
        check("energy_kept", {msg, value}, {4'hF, energy});
        goto_met(3'h1);
        check("peak_clr", {msg, value}, 20'hF0000);
        $display("retention test done");
        {gnd, ld_set} = {1'b0, 3'h1};
        trip(5'h01);
        for (int k = 0; k < 4; k++) begin
            press(0);
            check("ptr_nogd", 20'(cur_ptr), 20'(PTRS[(k == 3) ? 4 : k]));
        end
        press(1);
        cyc(700);
        check("thermal_long", 20'(thermal), 20'h1);
        $display("option test done");
        rst = 1'b1;
        cyc(2);
        check("in_reset", 20'({msg, met_ptr, led_ld, rl_ld}), 20'h0);
        rst = 1'b0;
        cyc(2);
        check("after_reset", {msg, value}, 20'hF0000);
        check("after_reset_ptr", 20'(met_ptr), 20'h1);
        $display("reset test done");
        complete_run();
    end
endmodule
bind tae_annunciator tae_monitor #(.TICK_CYCLES(TICK_CYCLES), .HILOAD_S(HILOAD_S)) i_tae_monitor (
    .clk, .rst, .overload_pin, .reset_btn_pin, .trip_ld, .trip_sd, .trip_fast_fault_trip_code, .trip_gnd,
    .trip_override, .led_long_delay, .led_short_delay, .led_fast_fault_trip_code, .led_ground, .led_high_load,
    .led_cur_ptr, .led_met_ptr, .relay_long_delay, .relay_short_circuit, .relay_high_load,
    .disp_msg);
